// File: hdl/acr_pkg.sv
// Constants, types and register map of the channel and range configuration block
// Function
// RULE_01 - A select field bits 3:0 picks A input 0-7, supply or regulator monitor
// RULE_02 - A select field decodes codes exactly like the B select field
// RULE_03 - A select code 1011 makes the A conversion result read 0xAAAA
// RULE_04 - Two range registers cover A inputs 0-7, two cover B inputs 0-7
// RULE_05 - First A range register at address 0x04, reset 0x00FF, inputs 0-3
// RULE_06 - Input 3 in bits 7:6, 2 in 5:4, 1 in 3:2, 0 in 1:0
// RULE_07 - Range code 00 or 11 is 10 V, 01 is 2.5 V, 10 is 5 V
// RULE_08 - Every 2-bit range field resets to 0x3, the 10 V range
// RULE_09 - Word bits 15:9 carry register address, bit 8 reserved zero
// RULE_10 - Channel selection register sits at address 0x03 and picks next conversion source
// RULE_11 - B select field occupies bits 7:4 with the same code meanings
// RULE_12 - B select code 1011 makes the B conversion result read 0x5555
package acr_pkg;

  // ==========================================================================
  // Register indices; byte address is four times the index
  localparam logic [6:0] IDX_SOURCE_SEL  = 7'h03;
  localparam logic [6:0] IDX_RANGE_A_LO  = 7'h04;
  localparam logic [6:0] IDX_RANGE_A_HI  = 7'h05;
  localparam logic [6:0] IDX_RANGE_B_LO  = 7'h06;
  localparam logic [6:0] IDX_RANGE_B_HI  = 7'h07;
  localparam logic [6:0] IDX_STATUS      = 7'h08;
  localparam logic [6:0] IDX_RESULT_A    = 7'h09;
  localparam logic [6:0] IDX_RESULT_B    = 7'h0A;
  localparam int         BYTE_ADDR_LSB   = 2;

  // ==========================================================================
  // Word layout
  localparam int ADDR_FIELD_HI  = 15;
  localparam int ADDR_FIELD_LO  = 9;
  localparam int RSVD_BIT       = 8;
  localparam int DATA_HI        = 7;
  localparam int SEL_A_HI       = 3;
  localparam int SEL_A_LO       = 0;
  localparam int SEL_B_HI       = 7;
  localparam int SEL_B_LO       = 4;
  localparam int RANGE_W        = 2;
  localparam int STS_REJECT_BIT = 0;

  // ==========================================================================
  // Reset values
  localparam logic [7:0]  SOURCE_SEL_RST = 8'h00;
  localparam logic [7:0]  RANGE_RST      = 8'hFF;
  localparam logic [31:0] ZERO_WORD      = 32'h0000_0000;
  localparam logic [15:0] ZERO_HALF      = 16'h0000;

  // ==========================================================================
  // Select codes, identical for both converters
  localparam logic [3:0] SEL_LAST_INPUT = 4'h7;
  localparam logic [3:0] SEL_SUPPLY     = 4'h8;
  localparam logic [3:0] SEL_REGULATOR  = 4'h9;
  localparam logic [3:0] SEL_SELFTEST   = 4'hB;

  // Self-test patterns
  localparam logic [15:0] PATTERN_A = 16'hAAAA;
  localparam logic [15:0] PATTERN_B = 16'h5555;

  // ==========================================================================
  // Bipolar input ranges
  typedef enum logic [1:0] {
    ACR_RANGE_10V = 2'b00,
    ACR_RANGE_2V5 = 2'b01,
    ACR_RANGE_5V  = 2'b10
  } acr_range_type;

  // Range code to range; 11 also means 10 V
  function automatic acr_range_type decode_range(input logic [1:0] code);
    acr_range_type r;
    r = ACR_RANGE_10V;
    case (code)
      2'b01:   r = ACR_RANGE_2V5;
      2'b10:   r = ACR_RANGE_5V;
      default: r = ACR_RANGE_10V;
    endcase
    return r;
  endfunction

  // Register word: address field, zero reserved bit, data byte
  function automatic logic [31:0] pack_word(input logic [6:0] idx, input logic [7:0] data);
    return {ZERO_HALF, idx, 1'b0, data};
  endfunction

endpackage : acr_pkg

// File: hdl/acr_sel_if.sv
// Decoded source selection of one converter
interface acr_sel_if;
  logic [2:0] input_idx;
  logic       analog;
  logic       supply;
  logic       regulator;
  logic       selftest;
  logic       reserved;

  modport drv (
    output input_idx,
    output analog,
    output supply,
    output regulator,
    output selftest,
    output reserved
  );

  modport use_side (
    input input_idx,
    input analog,
    input supply,
    input regulator,
    input selftest,
    input reserved
  );
endinterface : acr_sel_if

// File: hdl/acr_sel_decode.sv
// Registered decoder of one converter's source select code
module acr_sel_decode (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // Select code
  input  wire logic [3:0] code,
  // Decoded selection
  acr_sel_if.drv          sel
);

  // ==========================================================================
  // Decode
  wire is_analog = (code <= acr_pkg::SEL_LAST_INPUT);  // RULE_01
  wire is_supply = (code == acr_pkg::SEL_SUPPLY);
  wire is_reg    = (code == acr_pkg::SEL_REGULATOR);
  wire is_test   = (code == acr_pkg::SEL_SELFTEST);
  wire is_rsvd   = !(is_analog || is_supply || is_reg || is_test);

  // ==========================================================================
  // Registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sel.input_idx <= 3'h0;
      sel.analog    <= 1'b1;
      sel.supply    <= 1'b0;
      sel.regulator <= 1'b0;
      sel.selftest  <= 1'b0;
      sel.reserved  <= 1'b0;
    end else begin
      sel.input_idx <= code[2:0];
      sel.analog    <= is_analog;
      sel.supply    <= is_supply;
      sel.regulator <= is_reg;
      sel.selftest  <= is_test;
      sel.reserved  <= is_rsvd;
    end
  end

endmodule // acr_sel_decode

// File: hdl/acr_config_regs.sv
// Channel and range configuration registers behind an Avalon-MM slave
module acr_config_regs (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Avalon-MM slave
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // Conversion datapath
  input  wire logic [15:0] conv_a_data,
  input  wire logic [15:0] conv_b_data,
  input  wire logic        conv_valid,
  output logic      [15:0] result_a,
  output logic      [15:0] result_b,
  output logic             result_valid,
  // First converter source
  output logic      [2:0]  a_input_idx,
  output logic             a_sel_analog,
  output logic             a_sel_supply,
  output logic             a_sel_regulator,
  output logic             a_sel_selftest,
  output logic             a_sel_reserved,
  // Second converter source
  output logic      [2:0]  b_input_idx,
  output logic             b_sel_analog,
  output logic             b_sel_supply,
  output logic             b_sel_regulator,
  output logic             b_sel_selftest,
  output logic             b_sel_reserved,
  // Input ranges, one field per input
  output logic [7:0][1:0]  range_scale_a,
  output logic [7:0][1:0]  range_scale_b
);

  // ==========================================================================
  // Register storage
  logic [7:0]  source_sel_r;
  logic [7:0]  range_a_lo_r;
  logic [7:0]  range_a_hi_r;
  logic [7:0]  range_b_lo_r;
  logic [7:0]  range_b_hi_r;
  logic        reject_r;
  logic [31:0] readdata_r;
  logic        waitrequest_r;
  logic [15:0] result_a_r;
  logic [15:0] result_b_r;
  logic        result_valid_r;
  logic [7:0][1:0] range_scale_a_r;
  logic [7:0][1:0] range_scale_b_r;

  // ==========================================================================
  // Bus decode
  // Byte address to word index; the bus is too narrow for a top index bit
  wire [6:0]  word_idx   = {1'b0, address[7:acr_pkg::BYTE_ADDR_LSB]};
  wire        req        = read || write;
  wire        wr_commit  = write && !waitrequest_r;
  wire [6:0]  wr_addr_f  = writedata[acr_pkg::ADDR_FIELD_HI:acr_pkg::ADDR_FIELD_LO];
  wire        wr_rsvd_f  = writedata[acr_pkg::RSVD_BIT];
  wire [7:0]  wr_byte    = writedata[acr_pkg::DATA_HI:0];
  wire        lanes_ok   = byteenable[0] && byteenable[1];

  // Address field must name the target and reserved bit must be zero
  wire        word_ok    = lanes_ok && (wr_addr_f == word_idx) && !wr_rsvd_f;  // RULE_09

  wire        hit_src    = (word_idx == acr_pkg::IDX_SOURCE_SEL);  // RULE_10
  wire        hit_a_lo   = (word_idx == acr_pkg::IDX_RANGE_A_LO);  // RULE_05
  wire        hit_a_hi   = (word_idx == acr_pkg::IDX_RANGE_A_HI);
  wire        hit_b_lo   = (word_idx == acr_pkg::IDX_RANGE_B_LO);
  wire        hit_b_hi   = (word_idx == acr_pkg::IDX_RANGE_B_HI);
  wire        hit_sts    = (word_idx == acr_pkg::IDX_STATUS);
  wire        hit_res_a  = (word_idx == acr_pkg::IDX_RESULT_A);
  wire        hit_res_b  = (word_idx == acr_pkg::IDX_RESULT_B);
  wire        hit_cfg    = hit_src || hit_a_lo || hit_a_hi || hit_b_lo || hit_b_hi;

  wire        do_write   = wr_commit && hit_cfg && word_ok;
  wire        bad_write  = wr_commit && hit_cfg && !word_ok;
  wire        clr_reject = wr_commit && hit_sts && byteenable[0] && wr_byte[acr_pkg::STS_REJECT_BIT];

  // ==========================================================================
  // Read mux
  wire [31:0] rd_src   = acr_pkg::pack_word(acr_pkg::IDX_SOURCE_SEL, source_sel_r);
  wire [31:0] rd_a_lo  = acr_pkg::pack_word(acr_pkg::IDX_RANGE_A_LO, range_a_lo_r);
  wire [31:0] rd_a_hi  = acr_pkg::pack_word(acr_pkg::IDX_RANGE_A_HI, range_a_hi_r);
  wire [31:0] rd_b_lo  = acr_pkg::pack_word(acr_pkg::IDX_RANGE_B_LO, range_b_lo_r);
  wire [31:0] rd_b_hi  = acr_pkg::pack_word(acr_pkg::IDX_RANGE_B_HI, range_b_hi_r);
  wire [31:0] rd_sts   = {31'h0000_0000, reject_r};
  wire [31:0] rd_res_a = {acr_pkg::ZERO_HALF, result_a_r};
  wire [31:0] rd_res_b = {acr_pkg::ZERO_HALF, result_b_r};

  // Unmapped reads return zero
  wire [31:0] rd_mux =
    hit_src   ? rd_src   :
    hit_a_lo  ? rd_a_lo  :
    hit_a_hi  ? rd_a_hi  :
    hit_b_lo  ? rd_b_lo  :
    hit_b_hi  ? rd_b_hi  :
    hit_sts   ? rd_sts   :
    hit_res_a ? rd_res_a :
    hit_res_b ? rd_res_b :
    acr_pkg::ZERO_WORD;

  // ==========================================================================
  // Handshake: one wait cycle, then one cycle with waitrequest low
  wire waitrequest_nxt = !(req && waitrequest_r);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      waitrequest_r <= 1'b1;
      readdata_r    <= acr_pkg::ZERO_WORD;
    end else begin
      waitrequest_r <= waitrequest_nxt;
      if (read && waitrequest_r) begin
        readdata_r <= rd_mux;
      end
    end
  end

  // ==========================================================================
  // Configuration registers, updated at the accepting edge
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      source_sel_r <= acr_pkg::SOURCE_SEL_RST;
      range_a_lo_r <= acr_pkg::RANGE_RST;  // RULE_08
      range_a_hi_r <= acr_pkg::RANGE_RST;
      range_b_lo_r <= acr_pkg::RANGE_RST;
      range_b_hi_r <= acr_pkg::RANGE_RST;
    end else if (do_write) begin
      if (hit_src)  source_sel_r <= wr_byte;
      if (hit_a_lo) range_a_lo_r <= wr_byte;  // RULE_04
      if (hit_a_hi) range_a_hi_r <= wr_byte;
      if (hit_b_lo) range_b_lo_r <= wr_byte;
      if (hit_b_hi) range_b_hi_r <= wr_byte;
    end
  end

  // Sticky reject flag; a new reject wins over a clear
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reject_r <= 1'b0;
    end else if (bad_write) begin
      reject_r <= 1'b1;
    end else if (clr_reject) begin
      reject_r <= 1'b0;
    end
  end

  // ==========================================================================
  // Source decoders, one module for both converters
  acr_sel_if sel_a ();
  acr_sel_if sel_b ();

  acr_sel_decode u_dec_a (
    .clock (clock),
    .rst   (rst),
    .code  (source_sel_r[acr_pkg::SEL_A_HI:acr_pkg::SEL_A_LO]),  // RULE_01
    .sel   (sel_a.drv)
  );

  acr_sel_decode u_dec_b (  // RULE_02
    .clock (clock),
    .rst   (rst),
    .code  (source_sel_r[acr_pkg::SEL_B_HI:acr_pkg::SEL_B_LO]),  // RULE_11
    .sel   (sel_b.drv)
  );

  // ==========================================================================
  // Conversion results, replaced by fixed patterns in self-test
  wire [15:0] res_a_nxt = sel_a.selftest ? acr_pkg::PATTERN_A : conv_a_data;  // RULE_03
  wire [15:0] res_b_nxt = sel_b.selftest ? acr_pkg::PATTERN_B : conv_b_data;  // RULE_12

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      result_a_r     <= acr_pkg::ZERO_HALF;
      result_b_r     <= acr_pkg::ZERO_HALF;
      result_valid_r <= 1'b0;
    end else begin
      result_valid_r <= conv_valid;
      if (conv_valid) begin
        result_a_r <= res_a_nxt;
        result_b_r <= res_b_nxt;
      end
    end
  end

  // ==========================================================================
  // Range decode, one field per input
  wire [15:0] range_a_all = {range_a_hi_r, range_a_lo_r};
  wire [15:0] range_b_all = {range_b_hi_r, range_b_lo_r};

  wire [7:0][1:0] range_scale_a_nxt;
  wire [7:0][1:0] range_scale_b_nxt;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_range
      // Input n sits at bits 2n+1:2n
      wire [1:0] code_a = range_a_all[gi*acr_pkg::RANGE_W +: acr_pkg::RANGE_W];  // RULE_06
      wire [1:0] code_b = range_b_all[gi*acr_pkg::RANGE_W +: acr_pkg::RANGE_W];
      assign range_scale_a_nxt[gi] = acr_pkg::decode_range(code_a);  // RULE_07
      assign range_scale_b_nxt[gi] = acr_pkg::decode_range(code_b);
    end
  endgenerate

  // One process owns the whole decoded range word
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      range_scale_a_r <= {8{acr_pkg::ACR_RANGE_10V}};
      range_scale_b_r <= {8{acr_pkg::ACR_RANGE_10V}};
    end else begin
      range_scale_a_r <= range_scale_a_nxt;
      range_scale_b_r <= range_scale_b_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  assign readdata        = readdata_r;
  assign waitrequest     = waitrequest_r;
  assign result_a        = result_a_r;
  assign result_b        = result_b_r;
  assign result_valid    = result_valid_r;
  assign range_scale_a   = range_scale_a_r;
  assign range_scale_b   = range_scale_b_r;

  assign a_input_idx     = sel_a.input_idx;
  assign a_sel_analog    = sel_a.analog;
  assign a_sel_supply    = sel_a.supply;
  assign a_sel_regulator = sel_a.regulator;
  assign a_sel_selftest  = sel_a.selftest;
  assign a_sel_reserved  = sel_a.reserved;

  assign b_input_idx     = sel_b.input_idx;
  assign b_sel_analog    = sel_b.analog;
  assign b_sel_supply    = sel_b.supply;
  assign b_sel_regulator = sel_b.regulator;
  assign b_sel_selftest  = sel_b.selftest;
  assign b_sel_reserved  = sel_b.reserved;

endmodule // acr_config_regs

// File: dv/acr_config_regs_assertions.sv
// Port assertions of the channel and range configuration block
module acr_regs_chk (
  // Clock and reset
  input wire logic             clock,
  input wire logic             rst,
  // Register bus
  input wire logic [7:0]       address,
  input wire logic             read,
  input wire logic             write,
  input wire logic [31:0]      writedata,
  input wire logic [3:0]       byteenable,
  input wire logic [31:0]      readdata,
  input wire logic             waitrequest,
  // Datapath
  input wire logic [15:0]      conv_a_data,
  input wire logic             conv_valid,
  input wire logic [15:0]      result_a,
  input wire logic [15:0]      result_b,
  // Source and range outputs
  input wire logic [2:0]       a_input_idx,
  input wire logic             a_sel_analog,
  input wire logic             a_sel_selftest,
  input wire logic [2:0]       b_input_idx,
  input wire logic             b_sel_selftest,
  input wire logic [7:0][1:0]  range_scale_a,
  input wire logic [7:0][1:0]  range_scale_b
);
  timeunit 1ns;
  timeprecision 1ns;

  wire logic       acc_w = write && !waitrequest;
  wire logic [5:0] idx   = address[7:2];
  wire logic       wr_ok = acc_w && writedata[15:9] == {1'h0, idx} && !writedata[8] && byteenable[1:0] == 2'h3;
  logic [7:0]      d1_r;
  logic [7:0]      d2_r;

  // Write data as it was at the accept edge, two edges on
  always_ff @(posedge clock) begin
    d1_r <= writedata[7:0];
    d2_r <= d1_r;
  end

  function automatic logic [7:0] rmap(input logic [7:0] d);
    for (int i = 0; i < 4; i++) rmap[2*i+:2] = (d[2*i+:2] == 2'h3) ? 2'h0 : d[2*i+:2];
  endfunction

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  // ==========================================================================
  // Bus handshake
  wait_answer_a: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("request not answered after one wait cycle");
  wait_single_a: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low longer than one cycle");
  readback_a: assert property (read && !waitrequest && idx inside {[6'h03:6'h07]} |->
    readdata[15:8] == {1'h0, idx, 1'h0} && readdata[31:16] == 16'h0000)
    else $error("config readback lacks address field");

  // ==========================================================================
  // Source select and ranges
  src_decode_a: assert property (wr_ok && idx == 6'h03 |-> ##2 a_input_idx == d2_r[2:0] &&
    a_sel_analog == !d2_r[3] && a_sel_selftest == (d2_r[3:0] == 4'hB))
    else $error("first select decode wrong");
  src_b_a: assert property (wr_ok && idx == 6'h03 |-> ##2 b_input_idx == d2_r[6:4] &&
    b_sel_selftest == (d2_r[7:4] == 4'hB))
    else $error("second select decode wrong");
  refuse_write_a: assert property (acc_w && idx == 6'h03 && !wr_ok |-> ##2
    a_input_idx == $past(a_input_idx, 2) && b_input_idx == $past(b_input_idx, 2))
    else $error("malformed write changed the selection");
  range_a_a: assert property (wr_ok && idx == 6'h04 |-> ##2 range_scale_a[3:0] == rmap(d2_r))
    else $error("first range fields wrong");
  range_b_a: assert property (wr_ok && idx == 6'h06 |-> ##2 range_scale_b[3:0] == rmap(d2_r))
    else $error("second range fields wrong");

  // ==========================================================================
  // Results
  selftest_a_a: assert property (conv_valid && a_sel_selftest |=> result_a == 16'hAAAA)
    else $error("first self-test pattern missing");
  selftest_b_a: assert property (conv_valid && b_sel_selftest |=> result_b == 16'h5555)
    else $error("second self-test pattern missing");
  pass_a_a: assert property (conv_valid && !a_sel_selftest |=> result_a == $past(conv_a_data))
    else $error("first result not passed through");
endmodule // acr_regs_chk

bind acr_config_regs acr_regs_chk u_chk (
  .clock(clock), .rst(rst), .address(address), .read(read), .write(write), .writedata(writedata),
  .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest), .conv_a_data(conv_a_data),
  .conv_valid(conv_valid), .result_a(result_a), .result_b(result_b), .a_input_idx(a_input_idx),
  .a_sel_analog(a_sel_analog), .a_sel_selftest(a_sel_selftest), .b_input_idx(b_input_idx),
  .b_sel_selftest(b_sel_selftest), .range_scale_a(range_scale_a), .range_scale_b(range_scale_b)
);

// File: dv/acr_host_model.sv
// Host controller model driving the Avalon-MM register port
module acr_host_model (
  // Clock and slave answer
  input wire logic        clock,
  input wire logic        waitrequest,
  input wire logic [31:0] readdata,
  // Master request
  output logic [7:0]      address,
  output logic            read,
  output logic            write,
  output logic [31:0]     writedata,
  output logic [3:0]      byteenable
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    address = 8'h00;
    read = 1'h0;
    write = 1'h0;
    writedata = 32'h0000_0000;
    byteenable = 4'h0;
  end

  // Config word: address field, reserved bit zero, data
  function automatic logic [31:0] word(input logic [6:0] i, input logic [7:0] d);
    return {16'h0000, i, 1'h0, d};
  endfunction

  // One transfer, held until waitrequest is seen low
  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be,
                      output logic [31:0] q);
    @(posedge clock);
    address <= a;
    writedata <= d;
    byteenable <= be;
    read <= !we;
    write <= we;
    do begin
      @(posedge clock);
    end while (waitrequest !== 1'h0);
    q = readdata;
    read <= 1'h0;
    write <= 1'h0;
  endtask
endmodule // acr_host_model

// File: dv/adc_channel_and_range_config_test.sv
// Self-checking bench of the channel and range configuration block
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("CHECK FAILED %0t got %h expected %h", $time, (got), (exp)); end end

module adc_channel_and_range_config_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic             clock, rst, read, write, waitrequest, conv_valid, result_valid;
  logic [7:0]       address, d;
  logic [31:0]      writedata, readdata, q, rs;
  logic [3:0]       byteenable, sa, sb;
  logic [15:0]      conv_a_data, conv_b_data, result_a, result_b, da, db;
  logic [2:0]       a_input_idx, b_input_idx;
  wire  [4:0]       fa, fb;
  logic [6:0]       ri;
  logic [7:0][1:0]  range_scale_a, range_scale_b;
  int               seed = 10002;
  int               n_mismatch = 0;
  int               n_compared = 0;

  acr_config_regs dut (.clock(clock), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .conv_a_data(conv_a_data), .conv_b_data(conv_b_data), .conv_valid(conv_valid), .result_a(result_a),
    .result_b(result_b), .result_valid(result_valid), .a_input_idx(a_input_idx), .a_sel_analog(fa[4]),
    .a_sel_supply(fa[3]), .a_sel_regulator(fa[2]), .a_sel_selftest(fa[1]), .a_sel_reserved(fa[0]),
    .b_input_idx(b_input_idx), .b_sel_analog(fb[4]), .b_sel_supply(fb[3]), .b_sel_regulator(fb[2]),
    .b_sel_selftest(fb[1]), .b_sel_reserved(fb[0]), .range_scale_a(range_scale_a), .range_scale_b(range_scale_b));
  acr_host_model host (.clock(clock), .waitrequest(waitrequest), .readdata(readdata), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable));

  // Expected flags: analog, supply, regulator, self-test, reserved
  function automatic logic [4:0] fl(input logic [3:0] c);
    return {c < 4'h8, c == 4'h8, c == 4'h9, c == 4'hB, c > 4'h9 && c != 4'hB};
  endfunction
  function automatic logic [7:0] rmap(input logic [7:0] v);
    for (int i = 0; i < 4; i++) rmap[2*i+:2] = (v[2*i+:2] == 2'h3) ? 2'h0 : v[2*i+:2];
  endfunction
  task automatic wr(input logic [6:0] i, input logic [7:0] v);
    host.xfer(1'h1, {i[5:0], 2'h0}, host.word(i, v), 4'hF, q);
  endtask
  task automatic rd(input logic [6:0] i);
    host.xfer(1'h0, {i[5:0], 2'h0}, 32'h0000_0000, 4'hF, q);
  endtask
  task automatic final_report();
    $display("TB: %0d compared, %0d mismatched", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    clock = 1'h0;
    forever #25 clock = ~clock;
  end

  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    $display("CHECK FAILED %0t watchdog expired", $time);
    final_report();
  end

  initial begin
    rst = 1'h1;
    conv_valid = 1'h0;
    conv_a_data = 16'h0000;
    conv_b_data = 16'h0000;
    repeat (6) @(posedge clock);
    rst <= 1'h0;
    rd(7'h03); `CHK(q, 32'h0000_0600)
    for (int j = 4; j < 8; j++) begin
      rd(7'(j)); `CHK(q[15:0], {7'(j), 9'h0FF})
    end
    `CHK({range_scale_b, range_scale_a}, 32'h0000_0000)
    $display("test reset values done");
    for (int c = 0; c < 16; c++) begin
      sa = 4'(c);
      sb = ~sa;
      wr(7'h03, {sb, sa});
      repeat (2) @(posedge clock);
      `CHK(fa, fl(sa))
      `CHK(fb, fl(sb))
      `CHK({a_input_idx, b_input_idx}, {sa[2:0], sb[2:0]})
      da = 16'($random(seed));
      db = 16'($random(seed));
      conv_a_data <= da;
      conv_b_data <= db;
      conv_valid <= 1'h1;
      @(posedge clock);
      conv_valid <= 1'h0;
      @(posedge clock);
      `CHK(result_valid, 1'h1)
      `CHK(result_a, sa == 4'hB ? 16'hAAAA : da)
      `CHK(result_b, sb == 4'hB ? 16'h5555 : db)
      rd(7'h03); `CHK(q, {16'h0000, 7'h03, 1'h0, sb, sa})
    end
    $display("test source select done");
    for (int k = 0; k < 12; k++) begin
      ri = 7'(4 + k % 4);
      d = (k < 4) ? 8'h1B : 8'($random(seed));
      wr(ri, d);
      repeat (2) @(posedge clock);
      rs = {range_scale_b, range_scale_a};
      `CHK(rs[8*(ri-4)+:8], rmap(d))
      rd(ri); `CHK(q[15:0], {ri, 1'h0, d})
    end
    $display("test ranges done");
    host.xfer(1'h1, 8'h0C, host.word(7'h04, 8'h55), 4'hF, q);
    host.xfer(1'h1, 8'h0C, 32'h0000_0755, 4'hF, q);
    host.xfer(1'h1, 8'h0C, host.word(7'h03, 8'h55), 4'h1, q);
    rd(7'h03); `CHK(q[7:0], 8'h0F)
    rd(7'h08); `CHK(q[0], 1'h1)
    wr(7'h08, 8'h01);
    rd(7'h08); `CHK(q[0], 1'h0)
    rd(7'h30); `CHK(q, 32'h0000_0000)
    $display("test refusals done");
    final_report();
  end
endmodule // adc_channel_and_range_config_test
